// ===== cdr_pkg.sv
package cdr_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CSD_TAIL  = 8'h00;
  localparam logic [7:0] OFS_PROG      = 8'h04;
  localparam logic [7:0] OFS_CARD_ADDR = 8'h08;
  localparam logic [7:0] OFS_FEAT_HI   = 8'h0c;
  localparam logic [7:0] OFS_FEAT_LO   = 8'h10;
  localparam logic [7:0] OFS_XFER      = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_DRV_STAGE = 8'h1c;
  // ----------------------------------------------------------------
  // descriptor tail values and positions
  // ----------------------------------------------------------------
  localparam logic [3:0]  WBL_CODE    = 4'h9;
  localparam logic [15:0] BLOCK_BYTES = 16'h0200;
  localparam logic        PARTIAL_VAL = 1'b0;
  localparam logic        GRP_VAL     = 1'b0;
  localparam logic [1:0]  LAYOUT_VAL  = 2'h0;
  localparam logic        COPY_RST    = 1'b0;
  localparam logic        PERM_RST    = 1'b0;
  localparam logic        TMP_RST     = 1'b0;
  localparam logic        CSD_END_BIT = 1'b1;
  localparam int CSD_WBL_LSB  = 22;
  localparam int CSD_PART_BIT = 21;
  localparam int CSD_GRP_BIT  = 15;
  localparam int CSD_COPY_BIT = 14;
  localparam int CSD_PERM_BIT = 13;
  localparam int CSD_TMP_BIT  = 12;
  localparam int CSD_FMT_LSB  = 10;
  localparam int CSD_CRC_LSB  = 1;
  localparam int CSD_HEAD_W   = 96;
  localparam int CRC_BITS     = 120;
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam logic [6:0] CRC_RST  = 7'h00;
  // ----------------------------------------------------------------
  // feature register values
  // ----------------------------------------------------------------
  localparam logic [3:0] FEAT_STRUCT = 4'h0;
  localparam logic [3:0] PHYS_VER    = 4'h2;
  localparam logic       ERASE_STATE = 1'b1;
  localparam logic [2:0] SEC_VER     = 3'h3;
  localparam logic [3:0] WIDTH_CAP   = 4'h5;
  localparam logic       VER_EXT     = 1'b1;
  localparam logic [3:0] EXT_SEC     = 4'h0;
  localparam logic       LATER_VER   = 1'b1;
  localparam logic [5:0] FEAT_RSVD   = 6'h00;
  localparam logic [3:0] CMD_SUPPORT = 4'h4;
  localparam logic [7:0] ERASE_FILL  = 8'hff;
  localparam int WIDTH_ONE_BIT  = 0;
  localparam int WIDTH_FOUR_BIT = 2;
  // ----------------------------------------------------------------
  // control fields, responses
  // ----------------------------------------------------------------
  localparam int PROG_TMP_BIT   = 0;
  localparam int PROG_PERM_BIT  = 1;
  localparam int PROG_COPY_BIT  = 2;
  localparam int XFER_ERASE_BIT = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] ADDR_RST    = 16'h0000;

  typedef struct packed {
    logic [3:0] struct_ver;
    logic [3:0] phys_ver;
    logic       erase_state;
    logic [2:0] sec_ver;
    logic [3:0] width_cap;
    logic       ver_ext;
    logic [3:0] ext_sec;
    logic       later_ver;
    logic [5:0] rsvd;
    logic [3:0] cmd_support;
    logic [31:0] mfr;
  } cdr_feat_t;

  typedef struct packed {
    logic once_err;
    logic prot_err;
    logic len_err;
    logic ok;
  } cdr_status_t;
endpackage : cdr_pkg

// ===== cdr_crc7.sv
`timescale 1ns/1ps
module cdr_crc7
  import cdr_pkg::*;
(
  // message in
  input  wire logic [CRC_BITS-1:0] msg,
  // checksum out
  output logic      [6:0]          crc
);
  // ----------------------------------------------------------------
  // serial polynomial division, msb first
  // ----------------------------------------------------------------
  always_comb begin
    logic fb;
    fb  = 1'b0;
    crc = CRC_RST;
    for (int i = CRC_BITS - 1; i >= 0; i--) begin
      fb  = msg[i] ^ crc[6];
      crc = {crc[5:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RST);
    end
  end
endmodule : cdr_crc7

// ===== cdr_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - write block size code reads 9, 512-byte block writes accepted unless a lock bit is set
// - code means two to the code bytes; 0-8, 12-15 reserved, 11 is 2048
// - partial write bit reads 0: whole-block writes only
// - layout group bit and two-bit layout field read 0
// - copy bit reads original at reset, may change only once
// - permanent lock resets 0, once set refuses writes/erases, changes once
// - temporary lock defaults 0, while 1 blocks writes and erases
// - descriptor checksum recomputed whenever a modifiable field changes
// - 16-bit relative card address identifies the card
// - driver-stage register absent; access answers with an error
// - 64-bit read-only feature register, structure version 0000b
// - physical version field [59:56] reads 0010b
// - erase-state bit [55] reads 1, erased data reads all ones
// - security version [54:52] reads 011b
// - width capability [51:48] reads 0101b: one-line and four-line
// - version extension bit [47] reads 1
// - remaining fields: [46:43] 0, [42] 1, [35:32] 0100b
module cdr_regs
  import cdr_pkg::*;
#(
  parameter logic [CSD_HEAD_W-1:0] CSD_HEAD = '0,
  // arbitrary value
  parameter logic [31:0]           FEAT_MFR = 32'h0
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // axi4-lite write
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // card side
  input  wire logic        addr_load,
  input  wire logic [15:0] addr_value,
  output logic [15:0]      card_addr,
  output logic             write_inhibit,
  output logic             xfer_grant,
  output logic             xfer_erase,
  output logic [7:0]       erase_fill
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        awready_r, wready_r, bvalid_r, aw_have_r, w_have_r, rd_err;
  logic [7:0]  aw_addr_r, fill_r;
  logic [31:0] w_data_r, rdata_r, csd_low, rd_mux;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        arready_r, rvalid_r, inhibit_r, grant_r, erase_r, last_erase_r;
  logic        copy_r, perm_r, tmp_r, copy_used_r, perm_used_r;
  logic [6:0]  crc_r, crc_calc;
  logic [15:0] rca_r, last_len_r, req_len;
  cdr_status_t status_r, st_set, st_clr;
  cdr_feat_t   feat;
  logic        aw_take, w_take, wr_fire, bvalid_nxt;
  logic        aw_have_nxt, w_have_nxt, ar_take, rvalid_nxt;
  logic        sel_prog, sel_xfer, sel_stat, wr_ok_addr;
  logic        copy_try, perm_try, copy_blk, perm_blk;
  logic        lock_now, req_erase, prot_hit, len_hit, ok_hit;
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_awready     = awready_r;
  assign s_wready      = wready_r;
  assign s_bvalid      = bvalid_r;
  assign s_bresp       = bresp_r;
  assign s_arready     = arready_r;
  assign s_rvalid      = rvalid_r;
  assign s_rdata       = rdata_r;
  assign s_rresp       = rresp_r;
  assign card_addr     = rca_r;
  assign write_inhibit = inhibit_r;
  assign xfer_grant    = grant_r;
  assign xfer_erase    = erase_r;
  assign erase_fill    = fill_r;

  // ----------------------------------------------------------------
  // write channel handshakes
  // ----------------------------------------------------------------
  assign aw_take     = s_awvalid & awready_r;
  assign w_take      = s_wvalid & wready_r;
  assign wr_fire     = aw_have_r & w_have_r & ~bvalid_r;
  assign bvalid_nxt  = wr_fire | (bvalid_r & ~s_bready);
  assign aw_have_nxt = (aw_have_r | aw_take) & ~wr_fire;
  assign w_have_nxt  = (w_have_r | w_take) & ~wr_fire;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= ~aw_have_nxt & ~bvalid_nxt;
      wready_r  <= ~w_have_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        aw_addr_r <= s_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_wdata;
        w_strb_r <= s_wstrb;
      end
      if (wr_fire) begin
        bresp_r <= (!wr_ok_addr || copy_blk || perm_blk) ?
                   RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign sel_prog   = wr_fire & (aw_addr_r == OFS_PROG) & w_strb_r[0];
  assign sel_xfer   = wr_fire & (aw_addr_r == OFS_XFER) & (&w_strb_r[2:0]);
  assign sel_stat   = wr_fire & (aw_addr_r == OFS_STATUS) & w_strb_r[0];
  assign wr_ok_addr = (aw_addr_r == OFS_PROG) || (aw_addr_r == OFS_XFER) ||
                      (aw_addr_r == OFS_STATUS);
  assign copy_try   = sel_prog & (w_data_r[PROG_COPY_BIT] != copy_r);
  assign perm_try   = sel_prog & (w_data_r[PROG_PERM_BIT] != perm_r);
  assign copy_blk   = copy_try & copy_used_r;
  assign perm_blk   = perm_try & perm_used_r;
  assign lock_now   = perm_r | tmp_r;
  assign req_len    = w_data_r[15:0];
  assign req_erase  = w_data_r[XFER_ERASE_BIT];
  assign prot_hit   = sel_xfer & lock_now;
  assign len_hit    = sel_xfer & ~lock_now & ~req_erase &
                      (req_len != BLOCK_BYTES);
  assign ok_hit     = sel_xfer & ~prot_hit & ~len_hit;

  // ----------------------------------------------------------------
  // one-time and temporary protection bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      copy_r      <= COPY_RST;
      perm_r      <= PERM_RST;
      tmp_r       <= TMP_RST;
      copy_used_r <= 1'b0;
      perm_used_r <= 1'b0;
    end else begin
      if (copy_try && !copy_used_r) begin
        copy_r      <= w_data_r[PROG_COPY_BIT];
        copy_used_r <= 1'b1;
      end
      if (perm_try && !perm_used_r) begin
        perm_r      <= w_data_r[PROG_PERM_BIT];
        perm_used_r <= 1'b1;
      end
      if (sel_prog) begin
        tmp_r <= w_data_r[PROG_TMP_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // transfer requests and sticky status
  // ----------------------------------------------------------------
  always_comb begin
    st_set          = '0;
    st_set.ok       = ok_hit;
    st_set.len_err  = len_hit;
    st_set.prot_err = prot_hit;
    st_set.once_err = copy_blk | perm_blk;
    st_clr          = sel_stat ? cdr_status_t'(w_data_r[3:0]) : '0;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_r     <= '0;
      grant_r      <= 1'b0;
      erase_r      <= 1'b0;
      inhibit_r    <= 1'b0;
      last_len_r   <= '0;
      last_erase_r <= 1'b0;
      fill_r       <= ERASE_FILL;
    end else begin
      status_r  <= (status_r & ~st_clr) | st_set;
      grant_r   <= ok_hit;
      inhibit_r <= lock_now;
      if (ok_hit) begin
        erase_r <= req_erase;
      end
      if (sel_xfer) begin
        last_len_r   <= req_len;
        last_erase_r <= req_erase;
      end
    end
  end

  // ----------------------------------------------------------------
  // card address
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rca_r <= ADDR_RST;
    end else if (addr_load) begin
      rca_r <= addr_value;
    end
  end

  // ----------------------------------------------------------------
  // descriptor tail and checksum
  // ----------------------------------------------------------------
  always_comb begin
    csd_low                           = '0;
    csd_low[CSD_WBL_LSB +: 4]         = WBL_CODE;
    csd_low[CSD_PART_BIT]             = PARTIAL_VAL;
    csd_low[CSD_GRP_BIT]              = GRP_VAL;
    csd_low[CSD_FMT_LSB +: 2]         = LAYOUT_VAL;
    csd_low[CSD_COPY_BIT]             = copy_r;
    csd_low[CSD_PERM_BIT]             = perm_r;
    csd_low[CSD_TMP_BIT]              = tmp_r;
    csd_low[CSD_CRC_LSB +: 7]         = crc_r;
    csd_low[0]                        = CSD_END_BIT;
  end

  cdr_crc7 u_crc (
    .msg (CRC_BITS'({CSD_HEAD, csd_low[31:8]})),
    .crc (crc_calc)
  );
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      crc_r <= CRC_RST;
    end else begin
      crc_r <= crc_calc;
    end
  end

  // ----------------------------------------------------------------
  // feature register
  // ----------------------------------------------------------------
  always_comb begin
    feat             = '0;
    feat.struct_ver  = FEAT_STRUCT;
    feat.phys_ver    = PHYS_VER;
    feat.erase_state = ERASE_STATE;
    feat.sec_ver     = SEC_VER;
    feat.width_cap   = WIDTH_CAP;
    feat.ver_ext     = VER_EXT;
    feat.ext_sec     = EXT_SEC;
    feat.later_ver   = LATER_VER;
    feat.rsvd        = FEAT_RSVD;
    feat.cmd_support = CMD_SUPPORT;
    feat.mfr         = FEAT_MFR;
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign ar_take    = s_arvalid & arready_r;
  assign rvalid_nxt = ar_take | (rvalid_r & ~s_rready);
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    case (s_araddr)
      OFS_CSD_TAIL:  rd_mux = csd_low;
      OFS_PROG: begin
        rd_mux[PROG_COPY_BIT] = copy_r;
        rd_mux[PROG_PERM_BIT] = perm_r;
        rd_mux[PROG_TMP_BIT]  = tmp_r;
      end
      OFS_CARD_ADDR: rd_mux = 32'(rca_r);
      OFS_FEAT_HI:   rd_mux = feat[63:32];
      OFS_FEAT_LO:   rd_mux = feat[31:0];
      OFS_XFER: begin
        rd_mux[15:0]           = last_len_r;
        rd_mux[XFER_ERASE_BIT] = last_erase_r;
      end
      OFS_STATUS:    rd_mux = 32'(status_r);
      default:       rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_mux;
        rresp_r <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd(logic [7:0] ofs);
    ar_take && s_araddr == ofs;
  endsequence
  AST_WBL_CODE: assert property (
    s_rd(OFS_CSD_TAIL) |=> rvalid_r &&
      rdata_r[CSD_WBL_LSB +: 4] == WBL_CODE)
    else $error("block size code not 9");
  AST_NO_PARTIAL: assert property (
    s_rd(OFS_CSD_TAIL) |=> !rdata_r[CSD_PART_BIT] &&
      !rdata_r[CSD_GRP_BIT] && rdata_r[CSD_FMT_LSB +: 2] == LAYOUT_VAL)
    else $error("partial or layout bits not zero");
  AST_COPY_ONCE: assert property (copy_used_r |=> $stable(copy_r)[*2])
    else $error("copy bit changed twice");
  AST_PERM_ONCE: assert property (perm_used_r |=> $stable(perm_r))
    else $error("permanent lock changed twice");
  AST_LOCK_REFUSE: assert property (
    sel_xfer && lock_now |=> !grant_r && status_r.prot_err)
    else $error("write granted while locked");
  AST_CRC_FOLLOW: assert property (
    !$stable({copy_r, perm_r, tmp_r}) |-> ##1 crc_r == $past(crc_calc))
    else $error("checksum not recomputed");
  AST_ADDR_LOAD: assert property (
    addr_load |=> card_addr == $past(addr_value))
    else $error("card address not loaded");
  AST_DRV_ABSENT: assert property (
    s_rd(OFS_DRV_STAGE) |=> rvalid_r && rresp_r == RESP_SLVERR)
    else $error("driver stage register answered okay");
  AST_FEAT_HI: assert property (
    s_rd(OFS_FEAT_HI) |=> rdata_r[31:28] == FEAT_STRUCT &&
      rdata_r[27:24] == PHYS_VER && rdata_r[3:0] == CMD_SUPPORT)
    else $error("feature word fields wrong");
  AST_WIDTHS: assert property (
    s_rd(OFS_FEAT_HI) |=> rdata_r[16 + WIDTH_ONE_BIT] &&
      rdata_r[16 + WIDTH_FOUR_BIT] && rdata_r[23])
    else $error("width capability or erase state wrong");
  AST_LEN_REJECT: assert property (
    sel_xfer && !lock_now && !req_erase && req_len != BLOCK_BYTES
      |=> !grant_r && status_r.len_err)
    else $error("odd length write not rejected");
  AST_GRANT_PULSE: assert property (
    ok_hit |=> grant_r ##1 (!grant_r || $past(ok_hit)))
    else $error("grant not a single pulse");
  AST_WR_RESP: assert property (
    wr_fire |=> bvalid_r)
    else $error("write response missing");
  AST_B_HOLD: assert property (
    bvalid_r && !s_bready |=> bvalid_r && $stable(bresp_r))
    else $error("write response dropped before taken");
  AST_ERASE_FILL: assert property (##1 erase_fill == ERASE_FILL)
    else $error("erase fill not all ones");
endmodule : cdr_regs

// ===== cdr_host_model.sv
`timescale 1ns/1ps
module cdr_host_model
  import cdr_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // write side
  output logic [7:0]       s_awaddr,
  output logic             s_awvalid,
  input  wire logic        s_awready,
  output logic [31:0]      s_wdata,
  output logic [3:0]       s_wstrb,
  output logic             s_wvalid,
  input  wire logic        s_wready,
  input  wire logic [1:0]  s_bresp,
  input  wire logic        s_bvalid,
  output logic             s_bready,
  // read side
  output logic [7:0]       s_araddr,
  output logic             s_arvalid,
  input  wire logic        s_arready,
  input  wire logic [31:0] s_rdata,
  input  wire logic [1:0]  s_rresp,
  input  wire logic        s_rvalid,
  output logic             s_rready
);
  initial begin
    s_awaddr = 8'h00;
    s_awvalid = 1'b0;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hf;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_araddr = 8'h00;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
  end
  // ----------------------------------------------------------------
  // bus cycles, payload inverted once taken
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    if (a == OFS_DRV_STAGE) return;
    @(posedge sys_clk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= v;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_awvalid && s_awready) begin
        s_awvalid <= 1'b0;
        s_awaddr <= ~a;
      end
      if (s_wvalid && s_wready) begin
        s_wvalid <= 1'b0;
        s_wdata <= ~v;
      end
    end while (s_bvalid !== 1'b1);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge sys_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_arvalid && s_arready) begin
        s_arvalid <= 1'b0;
        s_araddr <= ~a;
      end
    end while (s_rvalid !== 1'b1);
    v = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
endmodule : cdr_host_model

// ===== cdr_regs_test.sv
`timescale 1ns/1ps
module cdr_regs_test
  import cdr_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [95:0] HEAD = 96'h0123_4567_89ab_cdef_0f1e_2d3c;
  logic        sys_clk, rstn, addr_load, write_inhibit;
  logic        xfer_grant, xfer_erase;
  logic [15:0] addr_value, card_addr;
  logic [7:0]  erase_fill, s_awaddr, s_araddr;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, r;
  logic        copy_m, perm_m, tmp_m, copy_chg, perm_chg;
  logic [15:0] seed = 16'h5802;
  logic [7:0]  ro[4] = '{OFS_CSD_TAIL, OFS_CARD_ADDR, OFS_FEAT_HI,
                         OFS_FEAT_LO};
  logic [7:0]  um[3] = '{OFS_DRV_STAGE, 8'h20, 8'hfc};
  int          fails = 0;
  int          check_count = 0;
  int          grants = 0;
  int          cycles = 0;

  cdr_regs #(.CSD_HEAD(HEAD)) dut (
    .sys_clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .addr_load, .addr_value, .card_addr, .write_inhibit,
    .xfer_grant, .xfer_erase, .erase_fill
  );
  cdr_host_model host (
    .sys_clk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (xfer_grant === 1'b1) grants++;
    if (cycles == 5000) begin
      fails++;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // helpers and model
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, e, input string w);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: %s got %h exp %h", $time, w, g, e);
    end
  endtask : chk

  function automatic logic [6:0] crc7(input logic [119:0] m);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      fb = m[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) c = c ^ CRC_POLY;
    end
    return c;
  endfunction : crc7

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic tail();
    logic [23:0] t;
    t = {6'h0, 4'h9, 7'h0, copy_m, perm_m, tmp_m, 4'h0};
    host.rd(OFS_CSD_TAIL, d, r);
    chk(32'(r), 32'(RESP_OKAY), "tail resp");
    chk(d & ~32'h0000_00fe, {t, 8'h01},
        "tail");
    chk(32'(d[7:1]), 32'(crc7({HEAD, t})), "crc");
  endtask : tail

  task automatic stat(input logic [3:0] e);
    host.rd(OFS_STATUS, d, r);
    chk(32'(d[3:0]), 32'(e), "status");
    host.wr(OFS_STATUS, 32'h0000_000f, r);
  endtask : stat

  task automatic xfer(input logic [16:0] v);
    int   g;
    logic lk;
    logic ok;
    g = grants;
    lk = perm_m | tmp_m;
    ok = !lk && (v[16] || v[15:0] == 16'h0200);
    host.wr(OFS_XFER, {15'h0, v}, r);
    @(posedge sys_clk);
    chk({r, 30'(grants - g)}, {RESP_OKAY, 30'(ok)}, "grant");
    if (ok) chk({v[16], 31'h0}, {xfer_erase, 31'h0}, "kind");
    host.rd(OFS_XFER, d, r);
    chk(d, {15'h0, v}, "last req");
    stat(lk ? 4'h4 : ok ? 4'h1 : 4'h2);
  endtask : xfer

  task automatic prog(input logic [2:0] v);
    logic bad;
    bad = (v[2] != copy_m && copy_chg) || (v[1] != perm_m && perm_chg);
    host.wr(OFS_PROG, {29'h0, v}, r);
    chk(32'(r), 32'(bad ? RESP_SLVERR : RESP_OKAY), "prog");
    if (!bad) begin
      copy_chg |= v[2] != copy_m;
      perm_chg |= v[1] != perm_m;
      {copy_m, perm_m, tmp_m} = v;
    end
    @(posedge sys_clk);
    chk(32'(write_inhibit), 32'(perm_m | tmp_m), "lock");
    host.rd(OFS_PROG, d, r);
    chk(d, {29'h0, copy_m, perm_m, tmp_m}, "prog rd");
    tail();
    stat(bad ? 4'h8 : 4'h0);
  endtask : prog

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    addr_load = 1'b0;
    addr_value = 16'h0000;
    {copy_m, perm_m, tmp_m, copy_chg, perm_chg} = 5'h00;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    chk(32'({card_addr, erase_fill, write_inhibit}), 32'h1fe, "rst");
    tail();
    host.rd(OFS_FEAT_HI, d, r);
    chk(d, 32'h02b5_8404, "feat hi");
    chk(32'(r), 32'(RESP_OKAY), "feat resp");
    host.rd(OFS_FEAT_LO, d, r);
    chk(d, 32'h0000_0000, "feat lo");
    foreach (ro[i]) begin
      host.wr(ro[i], 32'hffff_ffff, r);
      chk(32'(r), 32'(RESP_SLVERR), "ro");
    end
    foreach (um[i]) begin
      host.rd(um[i], d, r);
      chk({d[29:0], r}, 32'(RESP_SLVERR), "unmapped");
    end
    tail();
    repeat (2) begin
      seed = lfsr(seed);
      @(posedge sys_clk);
      addr_value <= seed;
      addr_load <= 1'b1;
      @(posedge sys_clk);
      addr_load <= 1'b0;
      @(posedge sys_clk);
      chk(32'(card_addr), 32'(seed), "addr");
      host.rd(OFS_CARD_ADDR, d, r);
      chk(d, {16'h0, seed}, "addr rd");
    end
    xfer(17'h0_0200);
    xfer(17'h0_01ff);
    xfer(17'h0_0201);
    xfer(17'h1_0123);
    repeat (3) begin
      seed = lfsr(seed);
      xfer({seed[0], seed});
    end
    prog(3'b001);
    xfer(17'h0_0200);
    xfer(17'h1_0000);
    prog(3'b000);
    prog(3'b100);
    prog(3'b000);
    prog(3'b110);
    xfer(17'h1_0200);
    prog(3'b100);
    close_out();
  end
endmodule : cdr_regs_test
